// >>> rtl/cam_lookup_host.sv
// Purpose: Wishbone-programmed controller that drives the ternary lookup engine pins.
// Assumes: Engine inputs sampled synchronously; one engine, highest priority in its chain.
// Notes:   One operation at a time; a command written while busy is dropped.
`timescale 1ns/1ps
`include "cam_host_regs.svh"

module cam_lookup_host (
  input  wire logic                      clk_i,                // System clock.
  input  wire logic                      rst_i,                // Synchronous reset.
  input  wire logic                      wb_cyc_i,             // Wishbone cycle.
  input  wire logic                      wb_stb_i,             // Wishbone strobe.
  input  wire logic                      wb_we_i,              // Wishbone write.
  input  wire logic [7:0]                wb_adr_i,             // Byte address.
  input  wire logic [3:0]                wb_sel_i,             // Byte enables.
  input  wire logic [31:0]               wb_dat_i,             // Write data.
  output logic      [31:0]               wb_dat_o,             // Read data.
  output logic                           wb_ack_o,             // Acknowledge.
  output cam_host_pkg::pin_drive_s       pins_o,               // Engine pin drive.
  input  wire logic [31:0]               bidir_data_lines_i,   // Data lines level.
  input  wire logic                      validity_line_i,      // Validity line level.
  input  wire logic [12:0]               active_addr_bus_i,    // Result bus level.
  input  wire logic                      match_flag_out_n_i,   // Engine match flag.
  output logic                           match_chain_in_n_o    // Chain input, held high.
);

  // ****************************************
  // State
  // ****************************************
  logic [31:0] cmd, next_cmd, addr, next_addr, value, next_value;
  logic [31:0] mask, next_mask, data, next_data, rdat, next_rdat;
  logic [12:0] cmpcode, next_cmpcode, result, next_result;
  logic [31:0] rdata, next_rdata;
  logic        ack, next_ack, start, next_start;
  logic        matched, next_matched, valid_rd, next_valid_rd;
  logic        beat, next_beat;
  logic [3:0]  cnt, next_cnt;
  cam_host_pkg::seq_e       st, next_st;
  cam_host_pkg::op_e        op, next_op;
  cam_host_pkg::pin_drive_s pins, next_pins, beat_pins;
  logic [31:0] enc_lo, enc_hi;
  logic        busy;
  cam_host_pkg::op_e        pin_op;
  logic        pin_beat;
  logic        chain_n;

  assign busy               = start | (st != cam_host_pkg::ST_IDLE);
  assign wb_dat_o           = rdat;
  assign wb_ack_o           = ack;
  assign pins_o             = pins;
  assign match_chain_in_n_o = chain_n;
  // The launch image decodes registers only, so it never loops back through the sequencer.
  assign pin_op             = (st == cam_host_pkg::ST_IDLE) ?
                              cam_host_pkg::op_e'(cmd[`CMD_OP_MSB:`CMD_OP_LSB]) : op;
  assign pin_beat           = (st != cam_host_pkg::ST_IDLE);

  ternary_pair_encoder #(.WIDTH(32)) u_enc (
    .value_i (value),
    .mask_i  (mask),
    .lower_o (enc_lo),
    .upper_o (enc_hi)
  );

  // Byte-lane merge so partial writes keep the untouched bytes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // Wishbone slave registers
  // ****************************************
  // Writes land on the request edge, the same edge that raises ack.
  always_comb begin
    next_ack     = wb_cyc_i & wb_stb_i & ~ack;
    next_start   = 1'b0;
    next_cmd     = cmd;
    next_addr    = addr;
    next_value   = value;
    next_mask    = mask;
    next_data    = data;
    next_cmpcode = cmpcode;
    next_rdat    = rdat;
    if (wb_cyc_i && wb_stb_i && !ack) begin
      if (wb_we_i) begin
        unique case (wb_adr_i)
          `REG_CMD: begin
            if (!busy) begin
              next_cmd   = merge(cmd, wb_dat_i, wb_sel_i);
              next_start = 1'b1;
            end
          end
          `REG_ADDR:    next_addr    = merge(addr, wb_dat_i, wb_sel_i);
          `REG_VALUE:   next_value   = merge(value, wb_dat_i, wb_sel_i);
          `REG_MASK:    next_mask    = merge(mask, wb_dat_i, wb_sel_i);
          `REG_DATA:    next_data    = merge(data, wb_dat_i, wb_sel_i);
          `REG_CMPCODE: next_cmpcode = 13'(merge({19'h00000, cmpcode}, wb_dat_i, wb_sel_i));
          default:      next_cmd     = cmd;
        endcase
        next_rdat = `WORD_RST;
      end else begin
        unique case (wb_adr_i)
          `REG_CMD:     next_rdat = cmd;
          `REG_ADDR:    next_rdat = addr;
          `REG_VALUE:   next_rdat = value;
          `REG_MASK:    next_rdat = mask;
          `REG_DATA:    next_rdat = data;
          `REG_STATUS:  next_rdat = {29'h0000000, valid_rd, matched, busy};
          `REG_RESULT:  next_rdat = {19'h00000, result};
          `REG_RDATA:   next_rdat = rdata;
          `REG_CMPCODE: next_rdat = {19'h00000, cmpcode};
          default:      next_rdat = `WORD_RST;  // Unmapped reads answer zero.
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack     <= 1'b0;
      start   <= 1'b0;
      cmd     <= `WORD_RST;
      addr    <= `WORD_RST;
      value   <= `WORD_RST;
      mask    <= `WORD_RST;
      data    <= `WORD_RST;
      cmpcode <= `CMPCODE_RST;
      rdat    <= `WORD_RST;
      chain_n <= 1'b1;
    end else begin
      ack     <= next_ack;
      start   <= next_start;
      cmd     <= next_cmd;
      addr    <= next_addr;
      value   <= next_value;
      mask    <= next_mask;
      data    <= next_data;
      cmpcode <= next_cmpcode;
      rdat    <= next_rdat;
      chain_n <= 1'b1;
    end
  end

  // ****************************************
  // Pin image of one strobe beat
  // ****************************************
  // Control-code cycles address 32-bit registers, so the segment is forced low.
  always_comb begin
    beat_pins                     = pins;
    beat_pins.write_n             = (pin_op == cam_host_pkg::OP_RAW_READ);
    beat_pins.addr_valid_select_n = (pin_op == cam_host_pkg::OP_TERN_COMPARE) ||
                                    ((pin_op == cam_host_pkg::OP_RAW_WRITE ||
                                      pin_op == cam_host_pkg::OP_RAW_READ) &&
                                     cmd[`CMD_AV_BIT]);
    beat_pins.addr_ctrl_bus       = (pin_op == cam_host_pkg::OP_TERN_COMPARE) ?
                                    cmpcode : addr[12:0];
    beat_pins.segment_select      = 1'b0;
    if (!beat_pins.addr_valid_select_n) begin
      if (pin_op == cam_host_pkg::OP_TERN_WRITE) begin
        beat_pins.segment_select = pin_beat;
      end else if (pin_op != cam_host_pkg::OP_DELETE) begin
        beat_pins.segment_select = cmd[`CMD_SEG_BIT];
      end
    end
    unique case (pin_op)
      cam_host_pkg::OP_TERN_WRITE:   beat_pins.bidir_data_lines = pin_beat ? enc_hi : enc_lo;
      cam_host_pkg::OP_TERN_COMPARE: beat_pins.bidir_data_lines = value;  // Key word.
      default:                       beat_pins.bidir_data_lines = data;
    endcase
    beat_pins.bidir_data_oe    = ~beat_pins.write_n;
    // Delete writes the empty level; entry writes mark the location valid.
    beat_pins.validity_line    = (pin_op == cam_host_pkg::OP_DELETE) ? 1'b1 :
                                 (pin_op == cam_host_pkg::OP_TERN_WRITE) ? 1'b0 :
                                 cmd[`CMD_VB_BIT];
    beat_pins.validity_line_oe = ~beat_pins.write_n &&
                                 (pin_op != cam_host_pkg::OP_TERN_COMPARE);
  end

  // ****************************************
  // Strobe sequencer
  // ****************************************
  // The result bus is only read late in recovery, after the engine reopens its latch.
  always_comb begin
    next_st       = st;
    next_op       = op;
    next_beat     = beat;
    next_cnt      = cnt;
    next_pins     = pins;
    next_result   = result;
    next_matched  = matched;
    next_rdata    = rdata;
    next_valid_rd = valid_rd;
    unique case (st)
      cam_host_pkg::ST_IDLE: begin
        if (start) begin
          next_op   = cam_host_pkg::op_e'(cmd[`CMD_OP_MSB:`CMD_OP_LSB]);
          next_beat = 1'b0;
          // Undefined codes start nothing, so no stray strobe can write the engine.
          if (next_op != cam_host_pkg::OP_NONE && next_op <= cam_host_pkg::OP_DELETE) begin
            next_pins = beat_pins;
            next_st   = cam_host_pkg::ST_SETUP;
          end
        end
      end
      cam_host_pkg::ST_SETUP: begin
        next_pins.chip_enable_n = 1'b0;
        next_cnt                = 4'(`E_LOW_CYC - 1);
        next_st                 = cam_host_pkg::ST_STROBE;
      end
      cam_host_pkg::ST_STROBE: begin
        if (cnt == 4'h0) begin
          if (op == cam_host_pkg::OP_RAW_READ) begin
            next_rdata    = bidir_data_lines_i;
            next_valid_rd = ~validity_line_i;
          end
          next_pins.chip_enable_n    = 1'b1;
          next_pins.bidir_data_oe    = 1'b0;  // Engine floats the lines once enable is high.
          next_pins.validity_line_oe = 1'b0;
          next_pins.active_addr_oe_n = 1'b0;
          next_cnt                   = 4'(`E_HIGH_CYC - 1);
          next_st                    = cam_host_pkg::ST_RECOVER;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      cam_host_pkg::ST_RECOVER: begin
        if (cnt == 4'h0) begin
          next_result = active_addr_bus_i;
          if (op == cam_host_pkg::OP_TERN_COMPARE) begin
            next_matched = ~match_flag_out_n_i;
          end
          next_pins.active_addr_oe_n = 1'b1;
          if (op == cam_host_pkg::OP_TERN_WRITE && !beat) begin
            next_beat = 1'b1;
            next_pins = beat_pins;
            next_pins.active_addr_oe_n = 1'b1;
            next_st   = cam_host_pkg::ST_SETUP;
          end else begin
            next_st = cam_host_pkg::ST_IDLE;
          end
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st       <= cam_host_pkg::ST_IDLE;
      op       <= cam_host_pkg::OP_NONE;
      beat     <= 1'b0;
      cnt      <= 4'h0;
      pins     <= '{chip_enable_n: 1'b1, write_n: 1'b1, addr_valid_select_n: 1'b1,
                    active_addr_oe_n: 1'b1, default: '0};
      result   <= 13'h0000;
      matched  <= 1'b0;
      rdata    <= `WORD_RST;
      valid_rd <= 1'b0;
    end else begin
      st       <= next_st;
      op       <= next_op;
      beat     <= next_beat;
      cnt      <= next_cnt;
      pins     <= next_pins;
      result   <= next_result;
      matched  <= next_matched;
      rdata    <= next_rdata;
      valid_rd <= next_valid_rd;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_lower_half_enc: assert property (@(posedge clk_i) disable iff (rst_i)
    (op == cam_host_pkg::OP_TERN_WRITE && !pins.chip_enable_n && !pins.segment_select)
    |-> pins.bidir_data_lines == (value & mask))
    else $error("Lower half of ternary write is not value and mask.");

  chk_upper_half_enc: assert property (@(posedge clk_i) disable iff (rst_i)
    (op == cam_host_pkg::OP_TERN_WRITE && !pins.chip_enable_n && pins.segment_select)
    |-> pins.bidir_data_lines == (~value & mask))
    else $error("Upper half of ternary write is not inverted value and mask.");

  chk_pair_complement: assert property (@(posedge clk_i) disable iff (rst_i)
    ((enc_lo ^ enc_hi) & mask) == mask)
    else $error("Cared position is not stored as value and complement.");

  chk_dont_care_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ((enc_lo | enc_hi) & ~mask) == 32'h0000_0000)
    else $error("Don't-care position has a nonzero bit.");

  chk_reg_segment_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pins.chip_enable_n && pins.addr_valid_select_n) |-> !pins.segment_select)
    else $error("Segment select high during a register access.");

  chk_both_halves: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == cam_host_pkg::ST_IDLE && start &&
     cmd[`CMD_OP_MSB:`CMD_OP_LSB] == 3'h3)
    |-> ##[1:20] (!pins.chip_enable_n && !pins.segment_select)
        ##[1:20] (!pins.chip_enable_n && pins.segment_select))
    else $error("Ternary write did not strobe lower then upper half.");

  chk_strobe_width: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(pins.chip_enable_n) |-> !pins.chip_enable_n [*4] ##1 pins.chip_enable_n)
    else $error("Chip enable low time is not four cycles.");

  chk_write_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pins.chip_enable_n && !$past(pins.chip_enable_n))
    |-> ($stable(pins.bidir_data_lines) && $stable(pins.segment_select)))
    else $error("Data or segment changed while chip enable was low.");

endmodule

// >>> rtl/cam_host_regs.svh
// Purpose: Register offsets, command fields and strobe timing for the lookup-port controller.
// Assumes: 32-bit classic Wishbone, byte addresses, 100 MHz clock.
// Notes:   Definitions only; included by bare name.
`ifndef CAM_HOST_REGS_SVH
`define CAM_HOST_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define REG_CMD       8'h00
`define REG_ADDR      8'h04
`define REG_VALUE     8'h08
`define REG_MASK      8'h0C
`define REG_DATA      8'h10
`define REG_STATUS    8'h14
`define REG_RESULT    8'h18
`define REG_RDATA     8'h1C
`define REG_CMPCODE   8'h20

// ****************************************
// Command register fields
// ****************************************
`define CMD_OP_LSB    0
`define CMD_OP_MSB    2
`define CMD_SEG_BIT   3
`define CMD_VB_BIT    4
`define CMD_AV_BIT    5

// ****************************************
// Status register fields
// ****************************************
`define STAT_BUSY_BIT   0
`define STAT_MATCH_BIT  1
`define STAT_VALID_BIT  2

// ****************************************
// Reset values
// ****************************************
`define CMPCODE_RST   13'h0000
`define WORD_RST      32'h0000_0000

// ****************************************
// Strobe timing
// ****************************************
`define CLK_NS        10
`define E_LOW_NS      40
`define E_HIGH_NS     30
`define E_LOW_CYC     ((`E_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define E_HIGH_CYC    ((`E_HIGH_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// >>> rtl/cam_host_pkg.sv
// Purpose: Types shared by the lookup-port controller files.
// Assumes: Fixed 32-bit data lines and 13-bit address/control bus.
// Notes:   Constants live in cam_host_regs.svh.
package cam_host_pkg;

  // Operations that software may start through the command register.
  typedef enum logic [2:0] {
    OP_NONE         = 3'h0,
    OP_RAW_WRITE    = 3'h1,
    OP_RAW_READ     = 3'h2,
    OP_TERN_WRITE   = 3'h3,
    OP_TERN_COMPARE = 3'h4,
    OP_DELETE       = 3'h5
  } op_e;

  // Strobe sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_SETUP   = 4'b0010,
    ST_STROBE  = 4'b0100,
    ST_RECOVER = 4'b1000
  } seq_e;

  // Everything the controller drives toward the lookup engine, except the match chain input.
  typedef struct packed {
    logic        chip_enable_n;
    logic        write_n;
    logic        addr_valid_select_n;
    logic        segment_select;
    logic [12:0] addr_ctrl_bus;
    logic [31:0] bidir_data_lines;
    logic        bidir_data_oe;
    logic        validity_line;
    logic        validity_line_oe;
    logic        active_addr_oe_n;
  } pin_drive_s;

endpackage

// >>> rtl/ternary_pair_encoder.sv
// Purpose: Turns a value word and a care mask into the two stored halves of a ternary entry.
// Assumes: Mask bit 0 marks a don't-care position.
// Notes:   Pure combinational; the caller registers the result onto the pins.
`timescale 1ns/1ps

module ternary_pair_encoder #(
  parameter int WIDTH = 32
) (
  input  wire logic [WIDTH-1:0] value_i,  // Value word to store.
  input  wire logic [WIDTH-1:0] mask_i,   // Care mask, 0 means don't care.
  output logic      [WIDTH-1:0] lower_o,  // Word for the lower half.
  output logic      [WIDTH-1:0] upper_o   // Word for the upper half.
);

  // ****************************************
  // Per-position pair encoding
  // ****************************************
  // Each position gets value and complement, or zero in both when masked off.
  for (genvar n = 0; n < WIDTH; n++) begin : g_pair
    assign lower_o[n] = value_i[n] & mask_i[n];
    assign upper_o[n] = ~value_i[n] & mask_i[n];
  end

endmodule

// >>> verification/cam_engine_model.sv
// Purpose: Pin-level behavioural model of the ternary lookup engine.
// Assumes: Sixteen locations, indexed by the low four address/control bits.
// Notes:   Lines that nobody drives show the inverse of their last level.
`timescale 1ns/1ps

module cam_engine_model (
  input  wire logic                     clk_i,     // System clock, for line history.
  input  wire cam_host_pkg::pin_drive_s pins_i,    // Host pin drive.
  input  wire logic                     chain_n_i, // Match chain input.
  output logic      [31:0]              data_o,    // Resolved data line level.
  output logic                          valid_o,   // Resolved validity line level.
  output logic      [12:0]              result_o,  // Result bus level.
  output logic                          match_n_o  // Match flag, active low.
);
  logic [31:0] mem_lo [16] = '{default: 32'h0};
  logic [31:0] mem_hi [16] = '{default: 32'h0};
  logic        ok     [16] = '{default: 1'b0};
  logic [31:0] rd_word     = 32'h0;
  logic [31:0] last_data   = 32'h0;
  logic        rd_on       = 1'b0;
  logic        rd_valid    = 1'b1;
  logic        last_valid  = 1'b0;
  logic        was_cmp     = 1'b0;
  logic        hit         = 1'b0;
  logic [12:0] pend        = 13'h0;
  logic [12:0] shown       = 13'h0;
  logic [12:0] last_res    = 13'h0;
  logic [12:0] code        = 13'h0;
  logic [3:0]  idx         = 4'h0;

  // Everything is taken at the falling strobe edge; results wait for the rising one.
  // Only hardware control is modelled, so the write and select pins alone steer the cycle; a compare code on the bus is only recorded.
  always @(negedge pins_i.chip_enable_n) begin
    idx = pins_i.addr_ctrl_bus[3:0];
    if (pins_i.addr_valid_select_n) begin
      code    = pins_i.addr_ctrl_bus;
      was_cmp = 1'b1;
      hit     = 1'b0;
      pend    = 13'h1FFF;
      for (int i = 15; i >= 0; i--) begin
        if (ok[i] && (mem_lo[i] & ~data_o) == 32'h0 && (mem_hi[i] & data_o) == 32'h0) begin
          pend = 13'(i);
          hit  = 1'b1;
        end
      end
    end else if (!pins_i.write_n) begin
      if (pins_i.segment_select)
        mem_hi[idx] = data_o;
      else
        mem_lo[idx] = data_o;
      ok[idx] = !valid_o;
      pend    = {9'h0, idx};
    end else begin
      rd_word  = pins_i.segment_select ? mem_hi[idx] : mem_lo[idx];
      rd_valid = !ok[idx];
      rd_on    = 1'b1;
      pend     = {9'h0, idx};
    end
  end

  // The result latch opens only while the strobe is high.
  always @(posedge pins_i.chip_enable_n) begin
    rd_on = 1'b0;
    shown = pend;
    if (was_cmp)
      match_n_o = !(hit || !chain_n_i);
    was_cmp = 1'b0;
  end

  // Line resolution; a released line must not keep its old value, or stale reads pass.
  always_comb begin
    if (pins_i.bidir_data_oe)
      data_o = pins_i.bidir_data_lines;
    else if (rd_on && !pins_i.chip_enable_n)
      data_o = rd_word;
    else
      data_o = ~last_data;
    if (pins_i.validity_line_oe)
      valid_o = pins_i.validity_line;
    else if (rd_on && !pins_i.chip_enable_n)
      valid_o = rd_valid;
    else
      valid_o = ~last_valid;
  end
  // A lone engine is top of its chain, so its own enable alone rules the bus.
  assign result_o = pins_i.active_addr_oe_n ? ~last_res : shown;

  // History of the line levels for the release pattern.
  always @(posedge clk_i) begin
    last_data  <= data_o;
    last_valid <= valid_o;
    last_res   <= result_o;
  end
endmodule

// >>> verification/testbench.sv
// Purpose: Self-checking bench for the lookup-port controller against the engine model.
// Assumes: Classic Wishbone master, one operation polled to completion at a time.
// Notes:   Stored words are read back from the model; raw half-words are also read back through the controller.
`timescale 1ns/1ps
`include "cam_host_regs.svh"

module testbench;
  logic                     clk_i    = 1'b0;
  logic                     rst_i    = 1'b1;
  logic                     wb_cyc_i = 1'b0;
  logic                     wb_stb_i = 1'b0;
  logic                     wb_we_i  = 1'b0;
  logic [7:0]               wb_adr_i = 8'h00;
  logic [31:0]              wb_dat_i = 32'h0;
  logic [31:0]              wb_dat_o;
  logic                     wb_ack_o;
  cam_host_pkg::pin_drive_s pins;
  logic [31:0]              data_lvl;
  logic                     valid_lvl;
  logic [12:0]              res_lvl;
  logic                     match_n;
  logic                     chain_n;
  logic [31:0]              rd;
  int                       n_fail   = 0;
  int                       checked  = 0;
  int                       cycles   = 0;

  always #5 clk_i = ~clk_i;

  cam_lookup_host u_dut (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .wb_cyc_i           (wb_cyc_i),
    .wb_stb_i           (wb_stb_i),
    .wb_we_i            (wb_we_i),
    .wb_adr_i           (wb_adr_i),
    .wb_sel_i           (4'hF),
    .wb_dat_i           (wb_dat_i),
    .wb_dat_o           (wb_dat_o),
    .wb_ack_o           (wb_ack_o),
    .pins_o             (pins),
    .bidir_data_lines_i (data_lvl),
    .validity_line_i    (valid_lvl),
    .active_addr_bus_i  (res_lvl),
    .match_flag_out_n_i (match_n),
    .match_chain_in_n_o (chain_n)
  );
  cam_engine_model u_eng (
    .clk_i     (clk_i),
    .pins_i    (pins),
    .chain_n_i (chain_n),
    .data_o    (data_lvl),
    .valid_o   (valid_lvl),
    .result_o  (res_lvl),
    .match_n_o (match_n)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic results();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Start an operation and poll busy; the global timeout catches a hang.
  task automatic run(input logic [31:0] cmd);
    wb(1'b1, `REG_CMD, cmd);
    do wb(1'b0, `REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
  endtask

  task automatic tw(input logic [12:0] a, input logic [31:0] v, input logic [31:0] m);
    wb(1'b1, `REG_ADDR, {19'h0, a});
    wb(1'b1, `REG_VALUE, v);
    wb(1'b1, `REG_MASK, m);
    run(32'h3);
    wb(1'b0, `REG_RESULT, 32'h0);
    check(rd, {19'h0, a});
    check(u_eng.mem_lo[a[3:0]], v & m);
    check(u_eng.mem_hi[a[3:0]], ~v & m);
    check({31'h0, u_eng.ok[a[3:0]]}, 32'h1);
  endtask

  task automatic cmp(input logic [31:0] key, input logic [12:0] idx, input logic hit);
    wb(1'b1, `REG_VALUE, key);
    run(32'h4);
    wb(1'b0, `REG_RESULT, 32'h0);
    check(rd, {19'h0, idx});
    wb(1'b0, `REG_STATUS, 32'h0);
    check({31'h0, rd[1]}, {31'h0, hit});
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      results();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({30'h0, pins.chip_enable_n, pins.active_addr_oe_n}, 32'h3);
    check({31'h0, chain_n}, 32'h1);
    wb(1'b1, 8'h24, 32'hFFFF_FFFF);
    wb(1'b0, 8'h24, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, `REG_CMPCODE, 32'h0000_0123);
    // A /8 prefix sits behind a /16 prefix so the longer one wins.
    tw(13'h2, 32'h0A00_0000, 32'hFF00_0000);
    tw(13'h1, 32'h0A01_0000, 32'hFFFF_0000);
    check({8'h0, u_eng.mem_lo[2][23:0] | u_eng.mem_hi[2][23:0]}, 32'h0);
    cmp(32'h0A01_0203, 13'h1, 1'b1);
    check({19'h0, u_eng.code}, 32'h0000_0123);
    cmp(32'h0A02_0304, 13'h2, 1'b1);
    cmp(32'h0B00_0000, 13'h1FFF, 1'b0);
    // Deleting the /16 entry leaves only the /8 one to answer.
    wb(1'b1, `REG_ADDR, 32'h1);
    wb(1'b1, `REG_DATA, 32'h0);
    run(32'h5);
    wb(1'b0, `REG_RESULT, 32'h0);
    check(rd, 32'h1);
    check({31'h0, u_eng.ok[1]}, 32'h0);
    cmp(32'h0A01_0203, 13'h2, 1'b1);
    // Raw half-word access with segment select and validity.
    wb(1'b1, `REG_ADDR, 32'h5);
    wb(1'b1, `REG_DATA, 32'hDEAD_BEEF);
    run(32'h9);
    check(u_eng.mem_hi[5], 32'hDEAD_BEEF);
    run(32'hA);
    wb(1'b0, `REG_RDATA, 32'h0);
    check(rd, 32'hDEAD_BEEF);
    wb(1'b0, `REG_STATUS, 32'h0);
    check({31'h0, rd[2]}, 32'h1);
    run(32'h2);
    wb(1'b0, `REG_RDATA, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, `REG_ADDR, 32'h6);
    run(32'h11);
    check({31'h0, u_eng.ok[6]}, 32'h0);
    run(32'h2);
    wb(1'b0, `REG_STATUS, 32'h0);
    check({31'h0, rd[2]}, 32'h0);
    // A delete issued while a write is still running must be dropped.
    wb(1'b1, `REG_ADDR, 32'h7);
    wb(1'b1, `REG_CMD, 32'h1);
    run(32'h5);
    check({31'h0, u_eng.ok[7]}, 32'h1);
    // An undefined operation code with the empty level set must leave the engine untouched.
    run(32'h16);
    check({31'h0, u_eng.ok[7]}, 32'h1);
    results();
  end
endmodule
